//--- verilog/hcsc_checker.sv
// Host command status checker with AXI4-Lite status registers
// Operation
// (R1) Own-map read or write to missing address returns code 0x1.
// (R2) Unsupported target device value returns code 0x2.
// (R3) Write with register count other than one returns code 0x3; converters unchecked.
// (R4) Write to own read-only register returns 0x4; converters unchecked.
// (R5) Stream config write with too low bit rate returns 0x5.
// (R6) Guard engaged refuses guarded writes with 0x6; zero releases guard.
// (R7) Slot map write with unsupported arrangement returns 0x7.
// (R8) Failed converter init returns 0x8 and sets init failure flag.
// (R9) Failed converter register access returns 0x8; host reinitializes after reset.
// (R10) Converter count write outside 1 to 4 returns 0x8.
// (R11) Capture start or sync before init done returns 0x9.
// (R12) Faulty host link transfer does not execute, returns 0xA.
// (R13) During sync, sync or converter access returns 0xB.
// (R14) Host link transmit fault sets host link flag, no code.
// (R15) Streaming output fault sets stream link flag, no code.
// (R16) Failed command answers four-byte status code instead of data.
// (R17) Host error pin shows that last command failed.
// (R18) One code by fixed priority; rejected command is not executed.
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
module hcsc_checker
(
	input wire logic I_CLK,
	input wire logic I_SRST,
	input wire logic i_cmd_valid,
	input wire hcsc_pkg::hcsc_cmd_t i_cmd,
	input wire hcsc_pkg::hcsc_attr_t i_attr,
	input wire logic i_link_bad,
	input wire logic i_conv_done,
	input wire logic i_conv_fail,
	input wire logic i_init_ok,
	input wire logic i_sync_busy,
	input wire logic i_host_tx_fault,
	input wire logic i_stream_fault,
	output hcsc_pkg::hcsc_res_t o_res,
	output logic o_res_valid,
	output logic o_guard,
	output logic o_host_err,
	output logic o_irq,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready
);

	// ==========================================================
	// Verdict
	hcsc_pkg::hcsc_res_t verdict;
	logic conv_target;
	logic dev_bad;
	logic conv_wait_q;
	logic guard_q;
	logic [hcsc_pkg::EF_W-1:0] flag_q;
	logic [hcsc_pkg::EF_W-1:0] mask_q;
	logic [31:0] last_q;
	logic flag_rd;

	assign dev_bad = i_cmd.dev > hcsc_pkg::DEV_ALL;
	assign conv_target = i_cmd.dev != hcsc_pkg::DEV_SELF;

	// ==========================================================
	// Shared decoders
	// Own-map control write of the init value starts converter bring-up
	function automatic logic is_init_req(input hcsc_pkg::hcsc_cmd_t cmd,
		input hcsc_pkg::hcsc_attr_t attr);
		return !cmd.rd && cmd.dev == hcsc_pkg::DEV_SELF && attr.is_conv_ctl
			&& cmd.data[3:0] == hcsc_pkg::CTL_INIT;
	endfunction

	// A converter job only ever ends in success or the generic failure code
	function automatic logic [31:0] conv_code(input logic fail);
		return fail ? hcsc_pkg::ST_CMD_FAIL : hcsc_pkg::ST_OK;
	endfunction

	// Order: link first, since nothing in a corrupt frame can be trusted
	always_comb
	begin
		verdict = '0;
		verdict.err = 1'b1;
		if (i_link_bad)
			verdict.code = hcsc_pkg::ST_LINK_BAD; // R12
		else if (dev_bad)
			verdict.code = hcsc_pkg::ST_BAD_DEV; // R2
		else if (conv_target && i_sync_busy)
			verdict.code = hcsc_pkg::ST_SYNC_BUSY; // R13
		else if (!conv_target && !i_attr.addr_ok)
			verdict.code = hcsc_pkg::ST_BAD_ADDR; // R1
		else if (!i_cmd.rd && !conv_target && i_cmd.num != hcsc_pkg::ONE_REG)
			verdict.code = hcsc_pkg::ST_MULTI_WR; // R3
		else if (!i_cmd.rd && !conv_target && i_attr.read_only)
			verdict.code = hcsc_pkg::ST_READ_ONLY; // R4
		else if (!i_cmd.rd && !conv_target && guard_q && i_attr.guarded && !i_attr.is_guard)
			verdict.code = hcsc_pkg::ST_GUARDED; // R6
		else if (!i_cmd.rd && !conv_target && i_attr.is_stream_cfg && i_attr.rate_short)
			verdict.code = hcsc_pkg::ST_RATE_LOW; // R5
		else if (!i_cmd.rd && !conv_target && i_attr.is_slot_map && i_attr.slot_bad)
			verdict.code = hcsc_pkg::ST_BAD_SLOT; // R7
		else if (!i_cmd.rd && !conv_target && i_attr.is_conv_cnt
			&& (i_cmd.data[2:0] < hcsc_pkg::CONV_MIN || i_cmd.data[2:0] > hcsc_pkg::CONV_MAX
			|| i_cmd.data[31:3] != 29'h0))
			verdict.code = hcsc_pkg::ST_CMD_FAIL; // R10
		else if (!i_cmd.rd && !conv_target && i_attr.is_conv_ctl && i_sync_busy
			&& i_cmd.data[3:0] == hcsc_pkg::CTL_SYNC)
			verdict.code = hcsc_pkg::ST_SYNC_BUSY; // R13
		else if (!i_cmd.rd && !conv_target && i_attr.is_conv_ctl && !i_init_ok
			&& (i_cmd.data[3:0] == hcsc_pkg::CTL_RUN || i_cmd.data[3:0] == hcsc_pkg::CTL_SYNC))
			verdict.code = hcsc_pkg::ST_NOT_INIT; // R11
		else
		begin
			verdict.err = 1'b0;
			verdict.exec = 1'b1;
			verdict.code = hcsc_pkg::ST_OK;
		end
	end

	// ==========================================================
	// Result output; converter work waits for the outcome
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			o_res <= '0;
			o_res_valid <= 1'b0;
			conv_wait_q <= 1'b0;
		end
		else
		begin
			o_res_valid <= 1'b0;
			if (conv_wait_q && i_conv_done)
			begin
				conv_wait_q <= 1'b0;
				o_res_valid <= 1'b1;
				o_res.exec <= 1'b1;
				o_res.err <= i_conv_fail;
				o_res.code <= conv_code(i_conv_fail); // R8 R9
			end
			else if (i_cmd_valid && !conv_wait_q)
			begin
				o_res <= verdict; // R16 R18
				if (verdict.exec && (conv_target || is_init_req(i_cmd, i_attr)))
					conv_wait_q <= 1'b1;
				else
					o_res_valid <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Host error pin: set by a rejected or failed command, cleared when a command is accepted
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
			o_host_err <= 1'b0;
		else if (conv_wait_q && i_conv_done)
			o_host_err <= i_conv_fail; // R17
		else if (i_cmd_valid && !conv_wait_q && !verdict.exec)
			o_host_err <= 1'b1; // R17
		else if (i_cmd_valid && !conv_wait_q)
			o_host_err <= 1'b0;
	end

	// ==========================================================
	// Config guard register
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
			guard_q <= 1'b0;
		else if (i_cmd_valid && !conv_wait_q && verdict.exec && !i_cmd.rd
			&& !conv_target && i_attr.is_guard)
			guard_q <= i_cmd.data != 32'h0000_0000; // R6
	end

	// ==========================================================
	// Last status code
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
			last_q <= hcsc_pkg::CODE_RST;
		else if (conv_wait_q && i_conv_done)
			last_q <= conv_code(i_conv_fail);
		else if (i_cmd_valid && !conv_wait_q)
			last_q <= verdict.code;
	end

	// ==========================================================
	// Error flags, sticky; a set in the read cycle survives the clear
	logic [hcsc_pkg::EF_W-1:0] flag_set;
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
			flag_q <= '0;
		else
			flag_q <= (flag_rd ? '0 : flag_q) | flag_set;
	end
	logic init_pending_q;
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
			init_pending_q <= 1'b0;
		else if (i_cmd_valid && !conv_wait_q)
			init_pending_q <= verdict.exec && is_init_req(i_cmd, i_attr);
	end
	always_comb
	begin
		flag_set = '0;
		flag_set[hcsc_pkg::EF_INIT] = conv_wait_q && i_conv_done && i_conv_fail
			&& init_pending_q; // R8
		flag_set[hcsc_pkg::EF_HOST] = i_host_tx_fault; // R14
		flag_set[hcsc_pkg::EF_STREAM] = i_stream_fault; // R15
	end

	// ==========================================================
	// Interrupt and guard outputs
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
			o_irq <= 1'b0;
		else
			o_irq <= |(flag_q & mask_q);
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
			o_guard <= 1'b0;
		else
			o_guard <= guard_q;
	end

	// ==========================================================
	// AXI4-Lite write
	logic aw_have_q;
	logic w_have_q;
	logic [7:0] aw_q;
	logic [31:0] w_q;
	logic [3:0] ws_q;
	// Readies are flops: low from acceptance until the response is taken
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_q <= '0;
			w_q <= '0;
			ws_q <= '0;
			o_bvalid <= 1'b0;
			o_bresp <= hcsc_pkg::RESP_OK;
			mask_q <= hcsc_pkg::MASK_RST;
			o_awready <= 1'b1;
			o_wready <= 1'b1;
		end
		else
		begin
			if (i_awvalid && o_awready)
			begin
				aw_have_q <= 1'b1;
				aw_q <= i_awaddr;
				o_awready <= 1'b0;
			end
			if (i_wvalid && o_wready)
			begin
				w_have_q <= 1'b1;
				w_q <= i_wdata;
				o_wready <= 1'b0;
				ws_q <= i_wstrb;
			end
			if (aw_have_q && w_have_q)
			begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= hcsc_pkg::RESP_OK;
				if (aw_q == hcsc_pkg::OFS_MASK)
				begin
					if (ws_q[0])
						mask_q <= w_q[hcsc_pkg::EF_W-1:0];
				end
				else if (aw_q != hcsc_pkg::OFS_STATUS && aw_q != hcsc_pkg::OFS_LAST
					&& aw_q != hcsc_pkg::OFS_CTRL)
					o_bresp <= hcsc_pkg::RESP_ERR;
			end
			else if (o_bvalid && i_bready)
			begin
				o_bvalid <= 1'b0;
				o_awready <= 1'b1;
				o_wready <= 1'b1;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read; reading status clears it
	assign flag_rd = i_arvalid && o_arready && i_araddr == hcsc_pkg::OFS_STATUS;
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_rresp <= hcsc_pkg::RESP_OK;
			o_arready <= 1'b1;
		end
		else if (i_arvalid && o_arready)
		begin
			o_rvalid <= 1'b1;
			o_arready <= 1'b0;
			o_rresp <= hcsc_pkg::RESP_OK;
			case (i_araddr)
				hcsc_pkg::OFS_STATUS: o_rdata <= {29'h0, flag_q};
				hcsc_pkg::OFS_MASK: o_rdata <= {29'h0, mask_q};
				hcsc_pkg::OFS_LAST: o_rdata <= last_q;
				hcsc_pkg::OFS_CTRL: o_rdata <= {30'h0, init_pending_q, guard_q};
				default:
				begin
					o_rdata <= '0;
					o_rresp <= hcsc_pkg::RESP_ERR;
				end
			endcase
		end
		else if (o_rvalid && i_rready)
		begin
			o_rvalid <= 1'b0;
			o_arready <= 1'b1;
		end
	end

endmodule

//--- verilog/hcsc_pkg.sv
// Package for the host command status checker
package hcsc_pkg;

	// ==========================================================
	// Status codes
	localparam logic [31:0] ST_OK = 32'h0000_0000;
	localparam logic [31:0] ST_BAD_ADDR = 32'h0000_0001;
	localparam logic [31:0] ST_BAD_DEV = 32'h0000_0002;
	localparam logic [31:0] ST_MULTI_WR = 32'h0000_0003;
	localparam logic [31:0] ST_READ_ONLY = 32'h0000_0004;
	localparam logic [31:0] ST_RATE_LOW = 32'h0000_0005;
	localparam logic [31:0] ST_GUARDED = 32'h0000_0006;
	localparam logic [31:0] ST_BAD_SLOT = 32'h0000_0007;
	localparam logic [31:0] ST_CMD_FAIL = 32'h0000_0008;
	localparam logic [31:0] ST_NOT_INIT = 32'h0000_0009;
	localparam logic [31:0] ST_LINK_BAD = 32'h0000_000A;
	localparam logic [31:0] ST_SYNC_BUSY = 32'h0000_000B;

	// ==========================================================
	// Command field values
	localparam logic [2:0] DEV_SELF = 3'h0;
	localparam logic [2:0] DEV_ALL = 3'h5;
	localparam logic [3:0] CTL_RUN = 4'h1;
	localparam logic [3:0] CTL_INIT = 4'h2;
	localparam logic [3:0] CTL_SYNC = 4'h5;
	localparam logic [7:0] ONE_REG = 8'h01;
	localparam logic [2:0] CONV_MIN = 3'h1;
	localparam logic [2:0] CONV_MAX = 3'h4;

	// ==========================================================
	// Error flag word bit positions
	localparam int EF_INIT = 0;
	localparam int EF_HOST = 1;
	localparam int EF_STREAM = 2;
	localparam int EF_W = 3;

	// ==========================================================
	// AXI4-Lite register byte offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_MASK = 8'h04;
	localparam logic [7:0] OFS_LAST = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h0C;
	localparam logic [1:0] RESP_OK = 2'b00;
	localparam logic [1:0] RESP_ERR = 2'b10;

	// ==========================================================
	// Reset values
	localparam logic [EF_W-1:0] MASK_RST = 3'h0;
	localparam logic [31:0] CODE_RST = 32'h0000_0000;

	// Decoded command from the framing logic
	typedef struct packed {
		logic rd;
		logic [2:0] dev;
		logic [7:0] num;
		logic [15:0] addr;
		logic [31:0] data;
	} hcsc_cmd_t;

	// Facts about the addressed register and environment
	typedef struct packed {
		logic addr_ok;
		logic read_only;
		logic guarded;
		logic is_guard;
		logic is_stream_cfg;
		logic rate_short;
		logic is_slot_map;
		logic slot_bad;
		logic is_conv_cnt;
		logic is_conv_ctl;
	} hcsc_attr_t;

	// Verdict back to the framing logic
	typedef struct packed {
		logic err;
		logic exec;
		logic [31:0] code;
	} hcsc_res_t;

endpackage

//--- dv/hcsc_checker_sva.sv
// Concurrent checks on the status checker ports
`timescale 1ns/1ns
module hcsc_checker_sva
(
	input wire logic I_CLK,
	input wire logic I_SRST,
	input wire logic i_cmd_valid,
	input wire hcsc_pkg::hcsc_cmd_t i_cmd,
	input wire hcsc_pkg::hcsc_attr_t i_attr,
	input wire logic i_link_bad,
	input wire logic i_conv_done,
	input wire logic i_conv_fail,
	input wire logic i_host_tx_fault,
	input wire logic i_stream_fault,
	input wire hcsc_pkg::hcsc_res_t o_res,
	input wire logic o_res_valid,
	input wire logic o_guard,
	input wire logic o_host_err
);
	// ==========================================================
	// Helpers
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_SRST);
	wire own = i_cmd_valid && !i_link_bad && i_cmd.dev == hcsc_pkg::DEV_SELF;
	wire wr1 = own && i_attr.addr_ok && !i_cmd.rd && i_cmd.num == hcsc_pkg::ONE_REG;
	wire wok = wr1 && !i_attr.read_only;
	sequence s_ans(logic [31:0] c);
		##1 o_res_valid && o_res.code == c && o_res.err;
	endsequence
	// ==========================================================
	// Properties
	property p_link;
		i_cmd_valid && i_link_bad |-> s_ans(hcsc_pkg::ST_LINK_BAD) ##0 !o_res.exec;
	endproperty
	a_link: assert property (p_link) else $error("link fault code wrong");
	property p_dev;
		i_cmd_valid && !i_link_bad && i_cmd.dev > hcsc_pkg::DEV_ALL |-> s_ans(hcsc_pkg::ST_BAD_DEV);
	endproperty
	a_dev: assert property (p_dev) else $error("bad device code wrong");
	property p_addr;
		own && !i_attr.addr_ok |-> s_ans(hcsc_pkg::ST_BAD_ADDR);
	endproperty
	a_addr: assert property (p_addr) else $error("bad address code wrong");
	property p_multi;
		own && i_attr.addr_ok && !i_cmd.rd && i_cmd.num != hcsc_pkg::ONE_REG
			|-> s_ans(hcsc_pkg::ST_MULTI_WR);
	endproperty
	a_multi: assert property (p_multi) else $error("multi write code wrong");
	property p_ro;
		wr1 && i_attr.read_only |-> s_ans(hcsc_pkg::ST_READ_ONLY);
	endproperty
	a_ro: assert property (p_ro) else $error("read only code wrong");
	property p_guard;
		wok && o_guard && i_attr.guarded && !i_attr.is_guard |-> s_ans(hcsc_pkg::ST_GUARDED);
	endproperty
	a_guard: assert property (p_guard) else $error("guard code wrong");
	property p_rel;
		wok && i_attr.is_guard && i_cmd.data == 32'h0 |=> ##1 !o_guard;
	endproperty
	a_rel: assert property (p_rel) else $error("guard not released");
	property p_fail;
		i_conv_done && i_conv_fail |-> s_ans(hcsc_pkg::ST_CMD_FAIL);
	endproperty
	a_fail: assert property (p_fail) else $error("converter fail code wrong");
	property p_pin;
		o_res_valid |-> o_host_err == o_res.err && o_res.err == (o_res.code != hcsc_pkg::ST_OK);
	endproperty
	a_pin: assert property (p_pin) else $error("error pin or code mismatch");
	property p_quiet;
		(i_host_tx_fault || i_stream_fault) && !i_cmd_valid && !i_conv_done |=> !o_res_valid;
	endproperty
	a_quiet: assert property (p_quiet) else $error("fault produced a result");
endmodule

bind hcsc_checker hcsc_checker_sva hcsc_checker_sva_i (.*);

//--- dv/hcsc_host.sv
// Host model issuing decoded commands
`timescale 1ns/1ns
module hcsc_host
(
	input wire logic I_CLK,
	output logic o_valid,
	output hcsc_pkg::hcsc_cmd_t o_cmd,
	output hcsc_pkg::hcsc_attr_t o_attr,
	output logic o_bad
);
	// ==========================================================
	// Command issue
	initial
	begin
		o_valid = 1'h0;
		o_cmd = '0;
		o_attr = '0;
		o_bad = 1'h0;
	end
	// Released fields are inverted so stale values never look valid
	task automatic send(input hcsc_pkg::hcsc_cmd_t c, input hcsc_pkg::hcsc_attr_t a, input logic b);
		@(posedge I_CLK);
		o_valid <= 1'h1;
		o_cmd <= c;
		o_attr <= a;
		o_bad <= b;
		@(posedge I_CLK);
		o_valid <= 1'h0;
		o_cmd <= ~c;
		o_attr <= ~a;
		o_bad <= ~b;
	endtask
endmodule

//--- dv/testbench.sv
// Self-checking bench for the status checker
`timescale 1ns/1ns
module testbench;
	logic I_CLK, I_SRST = 1, i_cmd_valid, i_link_bad, i_conv_done = 0, i_conv_fail = 0;
	logic i_init_ok = 0, i_sync_busy = 0, i_host_tx_fault = 0, i_stream_fault = 0;
	logic o_res_valid, o_guard, o_host_err, o_irq, g = 0;
	hcsc_pkg::hcsc_cmd_t i_cmd, c;
	hcsc_pkg::hcsc_attr_t i_attr, a;
	hcsc_pkg::hcsc_res_t o_res;
	logic [7:0] i_awaddr = 0, i_araddr = 0;
	logic [31:0] i_wdata = 0, o_rdata, r, e;
	logic [3:0] i_wstrb = 4'hF;
	logic [1:0] o_bresp, o_rresp, rs;
	logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	int fail_count = 0, checked = 0, cyc = 0;
	hcsc_checker hcsc_checker_i (.*);
	hcsc_host hcsc_host_i (.I_CLK(I_CLK), .o_valid(i_cmd_valid), .o_cmd(i_cmd),
		.o_attr(i_attr), .o_bad(i_link_bad));
	// ==========================================================
	// Clock, timeout, reporting
	initial
	begin
		I_CLK = 0;
		forever #50 I_CLK = ~I_CLK;
	end
	always @(posedge I_CLK)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fail_count++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask
	// ==========================================================
	// Bus tasks
	task automatic axw(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] q);
		logic aw, w, b;
		@(posedge I_CLK);
		i_awaddr <= ad;
		i_wdata <= d;
		i_awvalid <= 1'h1;
		i_wvalid <= 1'h1;
		i_bready <= 1'h1;
		do
		begin
			@(negedge I_CLK);
			aw = o_awready;
			w = o_wready;
			b = o_bvalid;
			q = o_bresp;
			@(posedge I_CLK);
			if (aw)
				i_awvalid <= 1'h0;
			if (w)
				i_wvalid <= 1'h0;
		end
		while (!b);
		i_bready <= 1'h0;
	endtask
	task automatic rchk(input string n, input logic [7:0] ad, input logic [31:0] x,
		input logic [1:0] xr);
		logic ar, v;
		logic [31:0] d;
		@(posedge I_CLK);
		i_araddr <= ad;
		i_arvalid <= 1'h1;
		i_rready <= 1'h1;
		do
		begin
			@(negedge I_CLK);
			ar = o_arready;
			v = o_rvalid;
			d = o_rdata;
			rs = o_rresp;
			@(posedge I_CLK);
			if (ar)
				i_arvalid <= 1'h0;
		end
		while (!v);
		i_rready <= 1'h0;
		chk(n, d, x);
		chk("rresp", rs, xr);
	endtask
	task automatic cmd(input logic b, input logic job, input logic f, input logic [31:0] x);
		hcsc_host_i.send(c, a, b);
		if (job)
		begin
			@(negedge I_CLK);
			chk("early", o_res_valid, 0);
			@(posedge I_CLK);
			i_conv_done <= 1'h1;
			i_conv_fail <= f;
			@(posedge I_CLK);
			i_conv_done <= 1'h0;
		end
		@(negedge I_CLK);
		chk("valid", o_res_valid, 1);
		chk("code", o_res.code, x);
		chk("pin", o_host_err, x != 0);
		if (!job)
			chk("exec", o_res.exec, x == 0);
	endtask
	// ==========================================================
	// Expected code by fixed priority
	function automatic logic [31:0] exp_code(logic b, logic ini, logic sb);
		logic own, w;
		logic [3:0] k;
		own = c.dev == hcsc_pkg::DEV_SELF;
		w = !c.rd && own;
		k = c.data[3:0];
		if (b) return hcsc_pkg::ST_LINK_BAD;
		if (c.dev > hcsc_pkg::DEV_ALL) return hcsc_pkg::ST_BAD_DEV;
		if (!own && sb) return hcsc_pkg::ST_SYNC_BUSY;
		if (own && !a.addr_ok) return hcsc_pkg::ST_BAD_ADDR;
		if (w && c.num != hcsc_pkg::ONE_REG) return hcsc_pkg::ST_MULTI_WR;
		if (w && a.read_only) return hcsc_pkg::ST_READ_ONLY;
		if (w && g && a.guarded && !a.is_guard) return hcsc_pkg::ST_GUARDED;
		if (w && a.is_stream_cfg && a.rate_short) return hcsc_pkg::ST_RATE_LOW;
		if (w && a.is_slot_map && a.slot_bad) return hcsc_pkg::ST_BAD_SLOT;
		if (w && a.is_conv_cnt && (c.data < 1 || c.data > 4)) return hcsc_pkg::ST_CMD_FAIL;
		if (w && a.is_conv_ctl && k == hcsc_pkg::CTL_SYNC && sb) return hcsc_pkg::ST_SYNC_BUSY;
		if (w && a.is_conv_ctl && (k == hcsc_pkg::CTL_RUN || k == hcsc_pkg::CTL_SYNC) && !ini)
			return hcsc_pkg::ST_NOT_INIT;
		return hcsc_pkg::ST_OK;
	endfunction
	// ==========================================================
	// Main sequence
	initial
	begin
		void'($urandom(32'hdbed));
		repeat (6) @(posedge I_CLK);
		I_SRST <= 1'h0;
		repeat (300)
		begin
			r = $urandom;
			c = '0;
			c.rd = r[10];
			c.dev = (r[12:11] == 2'h0) ? {2'h3, r[13]} : hcsc_pkg::DEV_SELF;
			c.num = r[14] ? hcsc_pkg::ONE_REG : 8'h02;
			c.data = $urandom_range(0, 6);
			if (c.data == 2)
				c.data = 1;
			a = '0;
			a.addr_ok = r[0] | r[1];
			a.read_only = r[2] & r[3];
			a.guarded = r[4];
			a.rate_short = r[8];
			a.slot_bad = r[9];
			case (r[7:5])
				1: a.is_guard = 1'h1;
				2: a.is_stream_cfg = 1'h1;
				3: a.is_slot_map = 1'h1;
				4: a.is_conv_cnt = 1'h1;
				5: a.is_conv_ctl = 1'h1;
				default: ;
			endcase
			@(posedge I_CLK);
			i_init_ok <= r[15];
			i_sync_busy <= r[16];
			e = exp_code(&r[19:17], r[15], r[16]);
			cmd(&r[19:17], 0, 0, e);
			if (e == 0 && !c.rd && a.is_guard)
				g = c.data != 0;
			// Guard output lags the internal guard by a cycle
			@(negedge I_CLK);
			chk("guard", o_guard, g);
		end
		$display("test random done");
		@(posedge I_CLK);
		i_init_ok <= 1'h0;
		i_sync_busy <= 1'h0;
		c = '0;
		c.num = hcsc_pkg::ONE_REG;
		c.data = 32'h0000_0002;
		a = '0;
		a.addr_ok = 1'h1;
		a.is_conv_ctl = 1'h1;
		cmd(0, 1, 1, hcsc_pkg::ST_CMD_FAIL);
		c.data = 32'h0000_0005;
		cmd(0, 0, 0, hcsc_pkg::ST_NOT_INIT);
		@(posedge I_CLK);
		i_init_ok <= 1'h1;
		i_sync_busy <= 1'h1;
		cmd(0, 0, 0, hcsc_pkg::ST_SYNC_BUSY);
		c.dev = 3'h1;
		c.rd = 1'h1;
		a = '0;
		cmd(0, 0, 0, hcsc_pkg::ST_SYNC_BUSY);
		@(posedge I_CLK);
		i_sync_busy <= 1'h0;
		cmd(0, 1, 1, hcsc_pkg::ST_CMD_FAIL);
		c.dev = hcsc_pkg::DEV_ALL;
		cmd(0, 1, 0, hcsc_pkg::ST_OK);
		$display("test converter done");
		rchk("mask_rst", hcsc_pkg::OFS_MASK, 32'h0, hcsc_pkg::RESP_OK);
		@(posedge I_CLK);
		i_stream_fault <= 1'h1;
		@(posedge I_CLK);
		i_stream_fault <= 1'h0;
		repeat (2) @(negedge I_CLK);
		chk("irq_masked", o_irq, 0);
		axw(hcsc_pkg::OFS_MASK, 32'h0000_0007, rs);
		chk("bresp", rs, hcsc_pkg::RESP_OK);
		@(posedge I_CLK);
		i_host_tx_fault <= 1'h1;
		@(posedge I_CLK);
		i_host_tx_fault <= 1'h0;
		repeat (2) @(negedge I_CLK);
		chk("irq", o_irq, 1);
		rchk("status", hcsc_pkg::OFS_STATUS, 32'h7, hcsc_pkg::RESP_OK);
		repeat (2) @(negedge I_CLK);
		chk("irq_clr", o_irq, 0);
		rchk("status_clr", hcsc_pkg::OFS_STATUS, 32'h0, hcsc_pkg::RESP_OK);
		rchk("last", hcsc_pkg::OFS_LAST, hcsc_pkg::ST_OK, hcsc_pkg::RESP_OK);
		rchk("ctrl", hcsc_pkg::OFS_CTRL, {31'h0, g}, hcsc_pkg::RESP_OK);
		rchk("unmapped", 8'h10, 32'h0, hcsc_pkg::RESP_ERR);
		axw(8'h14, 32'h0000_0001, rs);
		chk("bresp_err", rs, hcsc_pkg::RESP_ERR);
		$display("test registers done");
		test_done();
	end
endmodule
